/* include/rsse_pkg.sv */
/*
 * Constants and types for the reset sampling and strap entry block.
 * Assumes a single 25 MHz clock; no other package is required.
 */
package rsse_pkg;

    // ----------------------------------------------------------------
    // bus control group
    // ----------------------------------------------------------------
    localparam int CTRL_W = 8;
    // control strobes are active low, so the inactive level is all ones
    localparam logic [CTRL_W-1:0] CTRL_INACTIVE = 8'hff;
    localparam logic [CTRL_W-1:0] CTRL_OE_ALL = 8'hff;
    localparam logic [CTRL_W-1:0] CTRL_OE_NONE = 8'h00;

    // ----------------------------------------------------------------
    // reset sequencing
    // ----------------------------------------------------------------
    // cycles for which control outputs are driven inactive before floating
    localparam int DRIVE_INACTIVE_CYCLES = 1;
    localparam int CNT_W = 2;
    localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
    localparam logic [CNT_W-1:0] CNT_LAST =
        CNT_W'(DRIVE_INACTIVE_CYCLES - 1);

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [2:0] UPPER_ADDR_RESET = 3'h0;
    localparam logic SYNC_RESET = 1'b0;
    localparam logic FLOAT_MODE_RESET = 1'b0;

    typedef enum logic [2:0] {
        RSSE_RUN         = 3'h1,
        RSSE_DRIVE_IDLE  = 3'h2,
        RSSE_FLOAT       = 3'h4
    } rsse_state_t;

endpackage : rsse_pkg

/* include/rsse_sync_if.sv */
/*
 * Carries the synchronised reset level from the synchroniser to the
 * sequencer. Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface rsse_sync_if;
    logic reset_sync_n;

    modport src (output reset_sync_n);
    modport dst (input reset_sync_n);
endinterface : rsse_sync_if

/* hw/rsse_reset_sync.sv */
/*
 * Two flip-flop synchroniser for the external reset pin.
 * Assumes the pin is asynchronous to clk and the clock is running.
 */
`timescale 1ns/10ps

module rsse_reset_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic external_reset_in_n,
    rsse_sync_if.src sync
);

    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // ----------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------
    always_comb begin
        next_stage1 = external_reset_in_n;
        next_stage2 = stage1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= rsse_pkg::SYNC_RESET;
            stage2 <= rsse_pkg::SYNC_RESET;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync.reset_sync_n = stage2;

endmodule : rsse_reset_sync

/* hw/rsse_reset_seq.sv */
/*
 * Reset sequencer: aborts bus activity on reset, turns the lock and
 * upper address pins into pulled-up inputs and samples the test float
 * strap on release.
 * Assumes a pad ring that resolves pins from out/oe/pullup signals and
 * a core that takes core_reset_n as its full reset.
 * A pin pulse shorter than one clock period may be missed, and a
 * release during the abort step returns straight to run.
 */
`timescale 1ns/10ps

module rsse_reset_seq (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic external_reset_in_n,
    input wire logic [rsse_pkg::CTRL_W-1:0] core_ctrl,
    input wire logic [rsse_pkg::CTRL_W-1:0] core_ctrl_oe,
    input wire logic core_lock,
    input wire logic core_addr19,
    input wire logic [2:0] core_upper_addr,
    input wire logic core_addr_oe,
    input wire logic lock_in,
    input wire logic addr19_test_float_strap_in,
    input wire logic [2:0] upper_addr_18_16_in,
    output logic [rsse_pkg::CTRL_W-1:0] ctrl_out,
    output logic [rsse_pkg::CTRL_W-1:0] ctrl_oe,
    output logic lock_out,
    output logic lock_oe,
    output logic addr19_test_float_strap_out,
    output logic addr19_test_float_strap_oe,
    output logic [2:0] upper_addr_18_16_out,
    output logic [2:0] upper_addr_18_16_oe,
    output logic pullup_en,
    output logic core_reset_n,
    output logic onchip_test_float_mode
);

    rsse_sync_if sync_if ();

    rsse_reset_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .external_reset_in_n(external_reset_in_n),
        .sync(sync_if.src)
    );

    rsse_pkg::rsse_state_t state;
    rsse_pkg::rsse_state_t next_state;
    logic [rsse_pkg::CNT_W-1:0] cnt;
    logic [rsse_pkg::CNT_W-1:0] next_cnt;
    logic float_mode;
    logic next_float_mode;

    logic [rsse_pkg::CTRL_W-1:0] next_ctrl_out;
    logic [rsse_pkg::CTRL_W-1:0] next_ctrl_oe;
    logic next_lock_out;
    logic next_lock_oe;
    logic next_a19_out;
    logic next_a19_oe;
    logic [2:0] next_ua_out;
    logic [2:0] next_ua_oe;
    logic next_pullup_en;
    logic next_core_reset_n;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // a low strap at release selects the test float mode
    function automatic logic strap_mode(
        input logic strap_in
    );
        return !strap_in;
    endfunction : strap_mode

    // every state but run keeps the pins and the core in reset
    function automatic logic holds_reset(
        input rsse_pkg::rsse_state_t s
    );
        return s != rsse_pkg::RSSE_RUN;
    endfunction : holds_reset

    // the control enables stay on only during the abort step
    function automatic logic [rsse_pkg::CTRL_W-1:0] reset_ctrl_oe(
        input rsse_pkg::rsse_state_t s
    );
        if (s == rsse_pkg::RSSE_DRIVE_IDLE) begin
            return rsse_pkg::CTRL_OE_ALL;
        end else begin
            return rsse_pkg::CTRL_OE_NONE;
        end
    endfunction : reset_ctrl_oe

    logic in_reset;
    assign in_reset = !sync_if.reset_sync_n;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_float_mode = float_mode;
        unique case (state)
            rsse_pkg::RSSE_RUN: begin
                if (in_reset) begin
                    next_state = rsse_pkg::RSSE_DRIVE_IDLE;
                    next_cnt = rsse_pkg::CNT_RESET;
                    next_float_mode = rsse_pkg::FLOAT_MODE_RESET;
                end
            end
            rsse_pkg::RSSE_DRIVE_IDLE: begin
                if (!in_reset) begin
                    next_state = rsse_pkg::RSSE_RUN;
                    next_float_mode = strap_mode(addr19_test_float_strap_in);
                end else if (cnt == rsse_pkg::CNT_LAST) begin
                    next_state = rsse_pkg::RSSE_FLOAT;
                end else begin
                    next_cnt = cnt + 2'h1;
                end
            end
            rsse_pkg::RSSE_FLOAT: begin
                if (!in_reset) begin
                    next_state = rsse_pkg::RSSE_RUN;
                    next_float_mode = strap_mode(addr19_test_float_strap_in);
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= rsse_pkg::RSSE_FLOAT;
            cnt <= rsse_pkg::CNT_RESET;
            float_mode <= rsse_pkg::FLOAT_MODE_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            float_mode <= next_float_mode;
        end
    end

    // ----------------------------------------------------------------
    // pin and core reset drive
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl_out = core_ctrl;
        next_ctrl_oe = core_ctrl_oe;
        next_lock_out = core_lock;
        next_lock_oe = core_addr_oe;
        next_a19_out = core_addr19;
        next_a19_oe = core_addr_oe;
        next_ua_out = core_upper_addr;
        next_ua_oe = {3{core_addr_oe}};
        next_pullup_en = 1'b0;
        next_core_reset_n = 1'b1;
        if (holds_reset(next_state)) begin
            next_core_reset_n = 1'b0;
            next_lock_oe = 1'b0;
            next_a19_oe = 1'b0;
            next_ua_oe = 3'h0;
            next_lock_out = 1'b1;
            next_a19_out = 1'b1;
            next_ua_out = rsse_pkg::UPPER_ADDR_RESET;
            next_pullup_en = 1'b1;
            next_ctrl_out = rsse_pkg::CTRL_INACTIVE;
            next_ctrl_oe = reset_ctrl_oe(next_state);
        end else if (next_float_mode) begin
            next_ctrl_oe = rsse_pkg::CTRL_OE_NONE;
            next_lock_oe = 1'b0;
            next_a19_oe = 1'b0;
            next_ua_oe = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_out <= rsse_pkg::CTRL_INACTIVE;
            ctrl_oe <= rsse_pkg::CTRL_OE_NONE;
            lock_out <= 1'b1;
            lock_oe <= 1'b0;
            addr19_test_float_strap_out <= 1'b1;
            addr19_test_float_strap_oe <= 1'b0;
            upper_addr_18_16_out <= rsse_pkg::UPPER_ADDR_RESET;
            upper_addr_18_16_oe <= 3'h0;
            pullup_en <= 1'b1;
            core_reset_n <= 1'b0;
            onchip_test_float_mode <= rsse_pkg::FLOAT_MODE_RESET;
        end else begin
            ctrl_out <= next_ctrl_out;
            ctrl_oe <= next_ctrl_oe;
            lock_out <= next_lock_out;
            lock_oe <= next_lock_oe;
            addr19_test_float_strap_out <= next_a19_out;
            addr19_test_float_strap_oe <= next_a19_oe;
            upper_addr_18_16_out <= next_ua_out;
            upper_addr_18_16_oe <= next_ua_oe;
            pullup_en <= next_pullup_en;
            core_reset_n <= next_core_reset_n;
            onchip_test_float_mode <= next_float_mode;
        end
    end

endmodule : rsse_reset_seq

/* dv/rsse_checker.sv */
/* port checker for the reset sequencer.
   assumes a bind onto rsse_reset_seq. */
`timescale 1ns/10ps
module rsse_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic external_reset_in_n,
    input wire logic addr19_test_float_strap_in,
    input wire logic [rsse_pkg::CTRL_W-1:0] ctrl_out,
    input wire logic [rsse_pkg::CTRL_W-1:0] ctrl_oe,
    input wire logic lock_oe,
    input wire logic addr19_test_float_strap_oe,
    input wire logic [2:0] upper_addr_18_16_oe,
    input wire logic pullup_en,
    input wire logic core_reset_n,
    input wire logic onchip_test_float_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_idle_then_float;
        ctrl_out == rsse_pkg::CTRL_INACTIVE
            && ctrl_oe == rsse_pkg::CTRL_OE_ALL
            ##1 ctrl_oe == rsse_pkg::CTRL_OE_NONE;
    endsequence
    a_reset_takes_hold: assert property (
        !external_reset_in_n [*3] |=> !core_reset_n)
        else $error("core reset not entered");
    a_sync_release: assert property (
        $rose(core_reset_n) |-> $past(external_reset_in_n, 3))
        else $error("release without synchronised pin");
    a_abort_sequence: assert property (
        $fell(core_reset_n) |-> s_idle_then_float)
        else $error("controls not driven idle then floated");
    a_pins_pulled_up: assert property (
        !core_reset_n |-> pullup_en && !lock_oe
            && !addr19_test_float_strap_oe && upper_addr_18_16_oe == 3'h0)
        else $error("pins not pulled-up inputs in reset");
    a_strap_capture: assert property (
        $rose(core_reset_n) |->
            onchip_test_float_mode == !$past(addr19_test_float_strap_in))
        else $error("strap not captured at release");
    a_mode_holds: assert property (
        core_reset_n && $past(core_reset_n)
            |-> $stable(onchip_test_float_mode))
        else $error("float mode changed while running");
    a_entry_clears: assert property (
        $fell(core_reset_n) |-> !onchip_test_float_mode)
        else $error("float mode kept through reset");
endmodule : rsse_checker

bind rsse_reset_seq rsse_checker u_chk (.clk(clk), .reset_n(reset_n),
    .external_reset_in_n(external_reset_in_n),
    .addr19_test_float_strap_in(addr19_test_float_strap_in),
    .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .lock_oe(lock_oe),
    .addr19_test_float_strap_oe(addr19_test_float_strap_oe),
    .upper_addr_18_16_oe(upper_addr_18_16_oe), .pullup_en(pullup_en),
    .core_reset_n(core_reset_n),
    .onchip_test_float_mode(onchip_test_float_mode));

/* dv/rsse_board.sv */
/* board reset circuit, strap and pads.
   assumes bench commands change at the falling edge. */
`timescale 1ns/10ps
module rsse_board (
    input wire logic clk,
    input wire logic hold_reset,
    input wire logic strap_low,
    input wire logic pullup_en,
    input wire logic lock_out,
    input wire logic lock_oe,
    input wire logic a19_out,
    input wire logic a19_oe,
    input wire logic [2:0] ua_out,
    input wire logic [2:0] ua_oe,
    output logic ext_n,
    output logic lock_in,
    output logic a19_in,
    output logic [2:0] ua_in
);
    logic t = 1'b0;
    always @(posedge clk) t <= ~t;
    assign ext_n = !hold_reset;
    // strap held until device leaves reset
    assign a19_in = a19_oe ? a19_out
        : (strap_low && (!ext_n || pullup_en)) ? 1'b0 : (pullup_en | t);
    assign lock_in = lock_oe ? lock_out : (pullup_en | t);
    for (genvar i = 0; i < 3; i++) begin : g_ua
        assign ua_in[i] = ua_oe[i] ? ua_out[i] : (pullup_en | t);
    end
endmodule : rsse_board

/* dv/rsse_reset_seq_bench.sv */
/* self-checking bench for rsse_reset_seq.
   assumes rsse_pkg and the board model are compiled first. */
`timescale 1ns/10ps
module rsse_reset_seq_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hold_reset = 1'b1;
    logic strap_low = 1'b0;
    logic [7:0] c_ctrl = 8'hff, c_oe = 8'h00, ctrl_out, ctrl_oe;
    logic c_lock = 1'b1, c_a19 = 1'b1, c_aoe = 1'b0, ext_n, pullup_en;
    logic lock_out, lock_oe, a19_out, a19_oe, lock_in, a19_in, core_rst_n;
    logic mode;
    logic [2:0] c_ua = 3'h0, ua_out, ua_oe, ua_in;
    int n_errors = 0, tests_run = 0, cycles = 0, exp_mode;
    always #20 clk = ~clk;
    rsse_reset_seq dut (.clk(clk), .reset_n(reset_n),
        .external_reset_in_n(ext_n), .core_ctrl(c_ctrl), .core_ctrl_oe(c_oe),
        .core_lock(c_lock), .core_addr19(c_a19), .core_upper_addr(c_ua),
        .core_addr_oe(c_aoe), .lock_in(lock_in),
        .addr19_test_float_strap_in(a19_in), .upper_addr_18_16_in(ua_in),
        .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .lock_out(lock_out),
        .lock_oe(lock_oe), .addr19_test_float_strap_out(a19_out),
        .addr19_test_float_strap_oe(a19_oe), .upper_addr_18_16_out(ua_out),
        .upper_addr_18_16_oe(ua_oe), .pullup_en(pullup_en),
        .core_reset_n(core_rst_n), .onchip_test_float_mode(mode));
    rsse_board board (.clk(clk), .hold_reset(hold_reset),
        .strap_low(strap_low), .pullup_en(pullup_en), .lock_out(lock_out),
        .lock_oe(lock_oe), .a19_out(a19_out), .a19_oe(a19_oe),
        .ua_out(ua_out), .ua_oe(ua_oe), .ext_n(ext_n), .lock_in(lock_in),
        .a19_in(a19_in), .ua_in(ua_in));
    task automatic test_done;
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_core(input logic lvl);
        for (int i = 0; i < 20 && core_rst_n !== lvl; i++) @(negedge clk);
        check("core_reset_n", 8'(core_rst_n), 8'(lvl));
    endtask : wait_core
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(95438));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        check("pullup_en", 8'(pullup_en), 8'h01);
        for (int r = 0; r < 8; r++) begin
            strap_low = 1'($urandom);
            {c_ctrl, c_oe, c_lock, c_a19, c_ua, c_aoe} = 22'($urandom);
            exp_mode = int'(strap_low);
            hold_reset = 1'b0;
            wait_core(1'b1);
            strap_low = ~strap_low;
            repeat (3) @(negedge clk);
            check("float_mode", 8'(mode), 8'(exp_mode));
            check("lock_oe", 8'(lock_oe), 8'(!exp_mode && c_aoe));
            check("ctrl_out", ctrl_out, c_ctrl);
            check("ctrl_oe", ctrl_oe, exp_mode ? 8'h00 : c_oe);
            check("lock_out", 8'(lock_out), 8'(c_lock));
            check("a19_out", 8'(a19_out), 8'(c_a19));
            check("a19_oe", 8'(a19_oe), 8'(!exp_mode && c_aoe));
            check("ua_out", 8'(ua_out), 8'(c_ua));
            check("ua_oe", 8'(ua_oe), 8'({3{!exp_mode && c_aoe}}));
            check("pullup_en", 8'(pullup_en), 8'h00);
            if (r == 5) begin
                reset_n = 1'b0;
                #1;
                check("core_reset_n", 8'(core_rst_n), 8'h00);
                @(negedge clk);
                reset_n = 1'b1;
            end else begin
                hold_reset = 1'b1;
                wait_core(1'b0);
                check("ctrl_out", ctrl_out, rsse_pkg::CTRL_INACTIVE);
                check("ctrl_oe", ctrl_oe, rsse_pkg::CTRL_OE_ALL);
                @(negedge clk);
                check("ctrl_oe", ctrl_oe, rsse_pkg::CTRL_OE_NONE);
            end
            check("float_mode", 8'(mode), 8'h00);
        end
        test_done();
    end
endmodule : rsse_reset_seq_bench
